// ==== ssp_sync_select.sv ====
`timescale 1ns/1ns

// Overview of operation
// [RULE1] Mux bit 4 picks hsync or green sync, mux bit 1 coast or vsync.
// [RULE2] Mux bit 2 picks raw vsync or the separator output for mux four.
// [RULE3] Interface bit 3 picks digital (0) or analog (1) sync for muxes 5-7.
// [RULE4] The separator is an 8-bit counter on a 5 MHz tick, 200 ns a count.
// [RULE5] Composite polarity is resolved before the counter, so both work.
// [RULE6] While hunting, the count climbs in a pulse and decays to zero after.
// [RULE7] Vsync is declared present once the count rises above the threshold.
// [RULE8] On detection the count clears, then rises only while sync is absent.
// [RULE9] Vsync ends when the absence count reaches the same threshold.
// [RULE10] After the end the counter clears and hunting starts again.
// [RULE11] The counter saturates at 255 instead of wrapping.
module ssp_sync_select #(
    parameter int unsigned TICK_CYC = ssp_pkg::SEP_TICK_CYC
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    // Control bytes and the composite polarity bit from the serial register bank
    input  wire logic [7:0]        mux_ctrl_i,
    input  wire logic [7:0]        if_sel_i,
    input  wire logic [7:0]        sep_thr_i,
    input  wire logic              csync_inv_i,
    // Analog-side sync pins
    input  wire logic              hsync_i,
    input  wire logic              green_embedded_sync_i,
    input  wire logic              vsync_i,
    input  wire logic              coast_i,
    input  wire logic              ana_de_i,
    // Digital receiver sync
    input  wire ssp_pkg::ssp_sync_t dig_sync_i,
    // Outputs
    output logic                   pll_ref_o,
    output logic                   pll_coast_o,
    output logic                   sep_vsync_o,
    output ssp_pkg::ssp_sync_t     sync_o,
    output logic [7:0]             sep_cnt_o
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (TICK_CYC < 1 || TICK_CYC > 256)
    begin : g_bad_tick
        $error("TICK_CYC must lie in 1..256");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [7:0] async_w;
    logic [7:0] meta_q;
    logic [7:0] pin_q;

    assign async_w = {hsync_i, green_embedded_sync_i, vsync_i,
                      coast_i, ana_de_i, dig_sync_i};

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= 8'h00;
            pin_q  <= 8'h00;
        end
        else
        begin
            meta_q <= async_w;
            pin_q  <= meta_q;
        end
    end

    logic               hs_s;
    logic               sog_s;
    logic               vs_s;
    logic               coast_s;
    logic               ade_s;
    ssp_pkg::ssp_sync_t dig_s;

    assign hs_s    = pin_q[7];
    assign sog_s   = pin_q[6];
    assign vs_s    = pin_q[5];
    assign coast_s = pin_q[4];
    assign ade_s   = pin_q[3];
    assign dig_s   = pin_q[2:0];

    // ------------------------------------------------------------
    // Select muxes
    // ------------------------------------------------------------
    logic sel12;
    logic sel3;
    logic sel4;
    logic sel_ana;
    logic mux12_w;
    logic mux3_w;
    logic mux4_w;
    logic sep_vs_q;
    logic csync_w;

    assign sel12   = mux_ctrl_i[ssp_pkg::MUX12_SEL_BIT];
    assign sel3    = mux_ctrl_i[ssp_pkg::MUX3_SEL_BIT];
    assign sel4    = mux_ctrl_i[ssp_pkg::MUX4_SEL_BIT];
    assign sel_ana = if_sel_i[ssp_pkg::IF_SEL_BIT];

    assign mux12_w = sel12 ? sog_s : hs_s;      // see [RULE1]
    assign mux3_w  = sel3 ? vs_s : coast_s;     // see [RULE1]
    assign mux4_w  = sel4 ? sep_vs_q : vs_s;    // see [RULE2]

    // Polarity is fixed upstream; the counter only ever sees active high
    assign csync_w = mux12_w ^ csync_inv_i;     // see [RULE5]

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pll_ref_o   <= 1'b0;
            pll_coast_o <= 1'b0;
            sync_o      <= '0;
        end
        else
        begin
            pll_ref_o   <= mux12_w;
            pll_coast_o <= mux3_w;
            if (sel_ana)                         // see [RULE3]
            begin
                sync_o <= '{hs: mux12_w, vs: mux4_w, de: ade_s};
            end
            else
            begin
                sync_o <= dig_s;
            end
        end
    end

    // ------------------------------------------------------------
    // 5 MHz tick
    // ------------------------------------------------------------
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

    logic [7:0] div_q;
    logic       tick_q;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            div_q  <= 8'h00;
            tick_q <= 1'b0;
        end
        else if (div_q == TICK_LAST)             // see [RULE4]
        begin
            div_q  <= 8'h00;
            tick_q <= 1'b1;
        end
        else
        begin
            div_q  <= div_q + 8'h01;
            tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Vertical sync separator
    // ------------------------------------------------------------
    ssp_pkg::ssp_sep_state_t st_q;
    ssp_pkg::ssp_sep_state_t st_d;
    logic [7:0]              cnt_q;
    logic [7:0]              cnt_d;
    logic                    at_max;

    assign at_max = (cnt_q == ssp_pkg::SEP_CNT_MAX);

    always_comb
    begin
        st_d  = st_q;
        cnt_d = cnt_q;
        case (st_q)
            ssp_pkg::SEP_SEEK:
            begin
                if (cnt_q > sep_thr_i)           // see [RULE7]
                begin
                    st_d  = ssp_pkg::SEP_HELD;
                    cnt_d = ssp_pkg::SEP_CNT_RST; // see [RULE8]
                end
                else if (tick_q && csync_w && !at_max)
                begin
                    cnt_d = cnt_q + 8'h01;       // see [RULE6] [RULE11]
                end
                else if (tick_q && !csync_w && cnt_q != 8'h00)
                begin
                    cnt_d = cnt_q - 8'h01;       // see [RULE6]
                end
            end
            ssp_pkg::SEP_HELD:
            begin
                if (cnt_q >= sep_thr_i)          // see [RULE9]
                begin
                    st_d  = ssp_pkg::SEP_SEEK;
                    cnt_d = ssp_pkg::SEP_CNT_RST; // see [RULE10]
                end
                else if (tick_q && !csync_w && !at_max)
                begin
                    cnt_d = cnt_q + 8'h01;       // see [RULE8] [RULE11]
                end
            end
            default:
            begin
                st_d  = ssp_pkg::SEP_SEEK;
                cnt_d = ssp_pkg::SEP_CNT_RST;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_q     <= ssp_pkg::SEP_SEEK;
            cnt_q    <= ssp_pkg::SEP_CNT_RST;
            sep_vs_q <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            sep_vs_q <= (st_d == ssp_pkg::SEP_HELD);
        end
    end

    assign sep_vsync_o = sep_vs_q;
    assign sep_cnt_o   = cnt_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_mux_hs_select: assert property ( // see [RULE1]
        @(posedge clk_i) disable iff (!rstn_i)
        $stable(sel12) |=>
            pll_ref_o == ($past(sel12) ? $past(sog_s) : $past(hs_s))
    ) else $error("hsync mux output does not follow its select");

    a_mux_coast_select: assert property ( // see [RULE1]
        @(posedge clk_i) disable iff (!rstn_i)
        $stable(sel3) |=>
            pll_coast_o == ($past(sel3) ? $past(vs_s) : $past(coast_s))
    ) else $error("coast mux output does not follow its select");

    a_mux_vs_select: assert property ( // see [RULE2]
        @(posedge clk_i) disable iff (!rstn_i)
        (sel_ana && sel4) ##1 (sel_ana && sel4) |->
            sync_o.vs == $past(sep_vs_q)
    ) else $error("vsync mux does not pass the separator output");

    a_mux_vs_raw: assert property ( // see [RULE2]
        @(posedge clk_i) disable iff (!rstn_i)
        (sel_ana && !sel4) |=> sync_o.vs == $past(vs_s)
    ) else $error("vsync mux does not pass the raw vsync input");

    a_if_select_digital: assert property ( // see [RULE3]
        @(posedge clk_i) disable iff (!rstn_i)
        !sel_ana |=> sync_o == $past(dig_s)
    ) else $error("digital sync not forwarded while digital selected");

    a_tick_spacing: assert property ( // see [RULE4]
        @(posedge clk_i) disable iff (!rstn_i)
        tick_q |=> !tick_q ##1 tick_q
    ) else $error("separator tick is not one pulse every 200 ns");

    a_seek_count_up: assert property ( // see [RULE6]
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ssp_pkg::SEP_SEEK && cnt_q <= sep_thr_i && tick_q &&
         csync_w && !at_max) |=> cnt_q == $past(cnt_q) + 8'h01
    ) else $error("counter did not climb during a sync pulse");

    a_seek_decay: assert property ( // see [RULE6]
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ssp_pkg::SEP_SEEK && cnt_q <= sep_thr_i && tick_q &&
         !csync_w && cnt_q != 8'h00) |=> cnt_q == $past(cnt_q) - 8'h01
    ) else $error("counter did not fall after the sync pulse");

    a_detect_clear: assert property ( // see [RULE7]
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ssp_pkg::SEP_SEEK && cnt_q > sep_thr_i) |=>
            st_q == ssp_pkg::SEP_HELD && cnt_q == 8'h00 && sep_vsync_o
    ) else $error("vsync not declared with a cleared counter");

    a_held_pause: assert property ( // see [RULE8]
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ssp_pkg::SEP_HELD && cnt_q < sep_thr_i && csync_w) |=>
            cnt_q == $past(cnt_q)
    ) else $error("counter moved while the pulse is present");

    a_end_clear: assert property ( // see [RULE9]
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ssp_pkg::SEP_HELD && cnt_q >= sep_thr_i) |=>
            st_q == ssp_pkg::SEP_SEEK && cnt_q == 8'h00 && !sep_vsync_o
    ) else $error("vsync end not declared or counter not cleared");

    a_cnt_saturate: assert property ( // see [RULE11]
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == ssp_pkg::SEP_SEEK && at_max && csync_w &&
         sep_thr_i == 8'hFF) |=> at_max
    ) else $error("separator counter wrapped past its maximum");

endmodule : ssp_sync_select

// ==== ssp_pkg.sv ====
package ssp_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SEP_TICK_NS   = 200;
    localparam int unsigned SEP_TICK_CYC  =
        (SEP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Separator counter
    // ------------------------------------------------------------
    localparam int unsigned SEP_CNT_W   = 8;
    localparam logic [7:0]  SEP_CNT_MAX = 8'hFF;
    localparam logic [7:0]  SEP_CNT_RST = 8'h00;

    // ------------------------------------------------------------
    // Serial register offsets and control bit positions
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_SEP_THR   = 8'h0F;
    localparam logic [7:0]  REG_IF_SEL    = 8'h11;
    localparam logic [7:0]  REG_MUX_CTRL  = 8'h12;
    localparam int unsigned MUX12_SEL_BIT = 4;
    localparam int unsigned MUX3_SEL_BIT  = 1;
    localparam int unsigned MUX4_SEL_BIT  = 2;
    localparam int unsigned IF_SEL_BIT    = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic hs;
        logic vs;
        logic de;
    } ssp_sync_t;

    typedef enum logic {
        SEP_SEEK,
        SEP_HELD
    } ssp_sep_state_t;

endpackage : ssp_pkg

// ==== ssp_src_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// Graphics source driving the sync pins
// ----------------------------------------
module ssp_src_model (
    // Clock
    input  wire logic clk_i,
    // Sync pins
    output logic      hs_o,
    output logic      sog_o,
    output logic      vs_o,
    output logic      coast_o,
    output logic      de_o
);
    initial {hs_o, sog_o, vs_o, coast_o, de_o} = 5'h00;

    // Pins move 1 ns after the edge, like a registered source
    task automatic pins(input logic [4:0] v);
        @(posedge clk_i);
        #1 {hs_o, sog_o, vs_o, coast_o, de_o} = v;
    endtask : pins

    // Composite sync on the green line, held v for n cycles
    task automatic lvl(input logic v, input int n);
        @(posedge clk_i);
        #1 sog_o = v;
        repeat (n - 1) @(posedge clk_i);
        #1;
    endtask : lvl
endmodule : ssp_src_model

// ==== sync_select_and_separator_tb.sv ====
`timescale 1ns/1ns
module sync_select_and_separator_tb;
    logic               clk_i       = 1'h0;
    logic               rstn_i      = 1'h0;
    logic [7:0]         mux_ctrl_i  = 8'h00;
    logic [7:0]         if_sel_i    = 8'h00;
    logic [7:0]         sep_thr_i   = 8'hFF;
    logic               csync_inv_i = 1'h0;
    ssp_pkg::ssp_sync_t dig_sync_i  = 3'h0;
    wire logic          hs, green_embedded_sync_input, vs, co, de;
    logic               pll_ref_o, pll_coast_o, sep_vsync_o;
    ssp_pkg::ssp_sync_t sync_o;
    logic [7:0]         sep_cnt_o, prev;
    logic [4:0]         v;
    logic [2:0]         exp_sync;
    logic               exp_ref;
    int                 fail_count = 0;
    int                 tests_run  = 0;

    always #50 clk_i = ~clk_i;

    ssp_src_model src (.clk_i(clk_i), .hs_o(hs), .sog_o(green_embedded_sync_input), .vs_o(vs),
                       .coast_o(co), .de_o(de));

    ssp_sync_select dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .mux_ctrl_i(mux_ctrl_i), .if_sel_i(if_sel_i), .sep_thr_i(sep_thr_i),
        .csync_inv_i(csync_inv_i), .hsync_i(hs), .green_embedded_sync_i(green_embedded_sync_input),
        .vsync_i(vs), .coast_i(co), .ana_de_i(de), .dig_sync_i(dig_sync_i),
        .pll_ref_o(pll_ref_o), .pll_coast_o(pll_coast_o),
        .sep_vsync_o(sep_vsync_o), .sync_o(sync_o), .sep_cnt_o(sep_cnt_o));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [7:0] e, g);
        tests_run++;
        if (e !== g)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc

    // Bounded wait; prev keeps the count of the cycle before the change
    task automatic wait_vs(input logic lv, input int lim);
        int t;
        t = 0;
        while (sep_vsync_o !== lv && t < lim)
        begin
            prev = sep_cnt_o;
            cyc(1);
            t++;
        end
        // A used-up bound counts as a mismatch; the run still ends below
        if (sep_vsync_o !== lv)
            chk("sep_vsync_o wait", lv, sep_vsync_o);
    endtask : wait_vs

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        cyc(6);
        rstn_i = 1'h1;
        for (int i = 0; i < 32; i++)
        begin
            v = i[4] ? 5'h0C : 5'h13;
            src.pins(v);
            mux_ctrl_i = {3'h0, i[0], 1'h0, i[2], i[1], 1'h0};
            if_sel_i   = {4'h0, i[3], 3'h0};
            dig_sync_i = i[4] ? 3'h2 : 3'h5;
            cyc(5);
            exp_ref  = i[0] ? v[3] : v[4];
            exp_sync = i[3] ? {exp_ref, i[2] ? 1'h0 : v[2], v[0]} : dig_sync_i;
            chk("pll_ref_o", exp_ref, pll_ref_o);
            exp_ref = i[1] ? v[2] : v[1];
            chk("pll_coast_o", exp_ref, pll_coast_o);
            chk("sync_o", exp_sync, sync_o);
        end
        $display("test mux routing done");

        // Let any count from the routing test drain before arming
        mux_ctrl_i = 8'h14;
        if_sel_i   = 8'h08;
        src.lvl(1'h0, 120);
        sep_thr_i = 8'h05;
        repeat (5)
        begin
            src.lvl(1'h1, 4);
            src.lvl(1'h0, 16);
            chk("sep_vsync_o short", 8'h00, sep_vsync_o);
        end
        chk("sep_cnt_o decay", 8'h00, sep_cnt_o);
        src.lvl(1'h1, 6);
        prev = sep_cnt_o;
        cyc(4);
        chk("sep_cnt_o rate", prev + 8'h02, sep_cnt_o);
        wait_vs(1'h1, 20);
        chk("sep_cnt_o entry", 8'h06, prev);
        chk("sep_cnt_o cleared", 8'h00, sep_cnt_o);
        cyc(10);
        chk("sep_cnt_o held", 8'h00, sep_cnt_o);
        src.lvl(1'h0, 4);
        src.lvl(1'h1, 6);
        chk("sep_vsync_o serration", 8'h01, sep_vsync_o);
        chk("sync_o.vs", 8'h01, sync_o.vs);
        src.lvl(1'h0, 1);
        wait_vs(1'h0, 30);
        chk("sep_cnt_o exit", 8'h05, prev);
        chk("sep_cnt_o restart", 8'h00, sep_cnt_o);
        $display("test separator done");

        // Active-low composite, resolved by the polarity input
        src.lvl(1'h1, 2);
        csync_inv_i = 1'h1;
        cyc(10);
        chk("sep_cnt_o idle", 8'h00, sep_cnt_o);
        src.lvl(1'h0, 1);
        wait_vs(1'h1, 30);
        chk("sep_cnt_o low entry", 8'h06, prev);
        src.lvl(1'h1, 1);
        wait_vs(1'h0, 30);
        chk("sep_cnt_o low exit", 8'h05, prev);
        $display("test polarity done");

        // Top threshold: count must pin at the maximum, never wrap
        csync_inv_i = 1'h0;
        sep_thr_i   = 8'hFF;
        src.lvl(1'h1, 600);
        chk("sep_cnt_o saturate", 8'hFF, sep_cnt_o);
        chk("sep_vsync_o saturate", 8'h00, sep_vsync_o);
        $display("test saturation done");
        give_verdict();
    end
endmodule : sync_select_and_separator_tb
